// ---- rtl/annunciator_outputs.sv ----
// Warning lamps, gear and reverse outputs, range switch speed correction
//
// Overview of operation
// - Per condition style: slow, normal, fast, steady
// - Priority fast, normal, slow, then steady
// - Defaults steady; temperature normal; pressure fast
// - Lamp on speed, pressure, temperature warnings
// - Lamp also flags refused requests
// - Up to three lamps, each own subset
// - Lamp state on pin and CAN signal
// - Optional triggers: neutral lock, display error
// - Gear output follows configured gear set
// - Reverse alert on lever, gear or motion
// - No switches: speed assumes high range
// - Decode two switches into range position
// - Switches fitted: speed uses detected range
// - Both switches off: screens show dashes
// - Range neutral: reported speed is zero
// - Neutral forced, latched until lever cycles
// - Both on: as neutral plus errors
// - Switch correction excludes electronic range function
module annunciator_outputs
  import annunciator_pkg::*;
#(
  parameter int NUM_LAMPS  = 1,
  parameter int SLOW_HALF  = SLOW_HALF_CYC,
  parameter int NORM_HALF  = NORM_HALF_CYC,
  parameter int FAST_HALF  = FAST_HALF_CYC
)
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Warning conditions, same clock
  input  wire logic [NUM_COND-1:0]         cond_active,
  // Configuration
  input  wire logic [2*NUM_COND-1:0]       cond_style,
  input  wire logic [NUM_COND-1:0]         trig_enable,
  input  wire logic [3*NUM_COND-1:0]       lamp_subset,
  input  wire logic [GEAR_SLOTS-1:0]       gear_set,
  input  wire logic                        range_sw_fitted,
  input  wire logic                        elec_range_enabled,
  // Transmission status
  input  wire gear_s                       gear_engaged,
  input  wire logic [1:0]                  lever_dir,
  input  wire logic                        lever_in_neutral,
  input  wire logic                        moving_reverse,
  input  wire logic [SPEED_W-1:0]          speed_high_range,
  input  wire logic [SPEED_W-1:0]          speed_low_range,
  // Range position switch pins
  input  wire logic                        range_high_sw,
  input  wire logic                        range_low_sw,
  // Lamp and alert outputs
  output logic [NUM_LAMPS-1:0]             warn_lamp,
  output logic                             can_warn_lamp,
  output logic                             gear_out,
  output logic                             reverse_alert,
  // Speed and range outputs
  output speed_report_s                    speed_report,
  output logic                             force_neutral,
  output logic                             err_range_high,
  output logic                             err_range_low,
  output logic                             config_error
);

  if (NUM_LAMPS < 1 || NUM_LAMPS > 3)
    $error("annunciator_outputs: NUM_LAMPS must be 1 to 3");
  if (!(FAST_HALF < NORM_HALF && NORM_HALF < SLOW_HALF))
    $error("annunciator_outputs: blink halves must rank fast<normal<slow");

  ////////////////////////////////////////////////////////////////////////////
  // Blink sources

  logic wave_slow;
  logic wave_norm;
  logic wave_fast;

  blink_gen #(.HALF_CYC(SLOW_HALF)) u_slow
  (
    .clock (clock),
    .rst   (rst),
    .wave  (wave_slow)
  );

  blink_gen #(.HALF_CYC(NORM_HALF)) u_norm
  (
    .clock (clock),
    .rst   (rst),
    .wave  (wave_norm)
  );

  blink_gen #(.HALF_CYC(FAST_HALF)) u_fast
  (
    .clock (clock),
    .rst   (rst),
    .wave  (wave_fast)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lamp arbitration, one per lamp output

  logic [NUM_COND-1:0]     trig_live;
  wire logic [3:0]         lamp_nxt [0:NUM_LAMPS];
  wire logic [NUM_LAMPS:0] lamp_r;

  // Main lamp sees all enabled triggers; neutral lock and display
  // error are only live when enabled, which they are not by default
  assign trig_live = cond_active & trig_enable;

  function automatic logic [3:0] styles_seen
  (
    input logic [NUM_COND-1:0]   act,
    input logic [2*NUM_COND-1:0] sty
  );
    logic [3:0] seen;
    seen = 4'h0;
    for (int i = 0; i < NUM_COND; i++)
    begin
      if (act[i])
        seen[sty[2*i +: 2]] = 1'b1;
    end
    return seen;
  endfunction

  function automatic logic resolve
  (
    input logic [3:0] seen,
    input logic       ws,
    input logic       wn,
    input logic       wf
  );
    logic r;
    if (seen[STYLE_FAST])
      r = wf;
    else if (seen[STYLE_NORMAL])
      r = wn;
    else if (seen[STYLE_SLOW])
      r = ws;
    else
      r = seen[STYLE_STEADY];
    return r;
  endfunction

  genvar g;
  generate
    for (g = 0; g <= NUM_LAMPS; g++)
    begin : g_lamp
      logic [NUM_COND-1:0] sel;
      logic                lit_r;
      // Slot 0 is the combined lamp, slots 1.. are the separate lamps
      if (g == 0)
        assign sel = trig_live;
      else
        assign sel = trig_live & lamp_subset[NUM_COND*(g-1) +: NUM_COND];
      assign lamp_nxt[g] = styles_seen(sel, cond_style);

      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          lit_r <= 1'b0;
        else
          lit_r <= resolve(lamp_nxt[g], wave_slow, wave_norm, wave_fast);
      end
      assign lamp_r[g] = lit_r;
    end
  endgenerate

  // With one lamp the pin carries the combined state
  localparam int PIN_LO = (NUM_LAMPS > 1) ? 1 : 0;
  assign warn_lamp     = lamp_r[PIN_LO +: NUM_LAMPS];
  assign can_warn_lamp = lamp_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Gear dependent and reverse alert outputs

  logic gear_out_r;
  logic reverse_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gear_out_r <= 1'b0;
    else
      gear_out_r <= gear_set[{gear_engaged.dir, gear_engaged.range}];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reverse_r <= 1'b0;
    else
      reverse_r <= (lever_dir == DIR_REVERSE) ||
                   (gear_engaged.dir == DIR_REVERSE) ||
                   moving_reverse;
  end

  assign gear_out      = gear_out_r;
  assign reverse_alert = reverse_r;

  ////////////////////////////////////////////////////////////////////////////
  // Range switch sampling and decode

  logic [1:0] sw_meta_r;
  logic [1:0] sw_sync_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sw_meta_r <= 2'h0;
      sw_sync_r <= 2'h0;
    end
    else
    begin
      sw_meta_r <= {range_high_sw, range_low_sw};
      sw_sync_r <= sw_meta_r;
    end
  end

  range_pos_e range_pos;
  logic       corr_on;

  // Correction only when switches are fitted and the electronic
  // range function is absent; both together raises config_error
  assign corr_on      = range_sw_fitted && !elec_range_enabled;
  assign config_error = range_sw_fitted && elec_range_enabled;

  always_comb
  begin
    case (sw_sync_r)
      2'b00:   range_pos = RNG_NEUTRAL;
      2'b01:   range_pos = RNG_LOW;
      2'b10:   range_pos = RNG_HIGH;
      default: range_pos = RNG_IMPOSSIBLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Corrected vehicle speed

  logic               range_lost;
  logic [SPEED_W-1:0] speed_r;
  logic               unknown_r;

  assign range_lost = corr_on &&
                      (range_pos == RNG_NEUTRAL ||
                       range_pos == RNG_IMPOSSIBLE);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      speed_r   <= SPEED_ZERO;
      unknown_r <= 1'b0;
    end
    else if (!corr_on)
    begin
      speed_r   <= speed_high_range;
      unknown_r <= 1'b0;
    end
    else if (range_lost)
    begin
      speed_r   <= SPEED_ZERO;
      unknown_r <= 1'b1;
    end
    else
    begin
      speed_r   <= (range_pos == RNG_LOW) ? speed_low_range
                                          : speed_high_range;
      unknown_r <= 1'b0;
    end
  end

  assign speed_report.speed   = speed_r;
  assign speed_report.unknown = unknown_r;

  ////////////////////////////////////////////////////////////////////////////
  // Neutral lock after range loss

  typedef enum logic [1:0] {
    NL_FREE,
    NL_LOCKED,
    NL_LEVER_SEEN
  } nlock_e;

  nlock_e nl_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      nl_r <= NL_FREE;
    else if (range_lost)
      nl_r <= NL_LOCKED;
    else
    begin
      case (nl_r)
        NL_FREE:       nl_r <= NL_FREE;
        NL_LOCKED:     if (lever_in_neutral) nl_r <= NL_LEVER_SEEN;
        NL_LEVER_SEEN: if (!lever_in_neutral && lever_dir != DIR_NEUTRAL)
                         nl_r <= NL_FREE;
        default:       nl_r <= NL_FREE;
      endcase
    end
  end

  assign force_neutral = range_lost || (nl_r != NL_FREE);

  ////////////////////////////////////////////////////////////////////////////
  // Impossible combination error flags

  logic err_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      err_r <= 1'b0;
    else
      err_r <= corr_on && (range_pos == RNG_IMPOSSIBLE);
  end

  assign err_range_high = err_r;
  assign err_range_low  = err_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_steady_only: assert property (@(posedge clock) disable iff (rst)
    (lamp_nxt[0] == 4'h1) |=> lamp_r[0])
    else $error("steady style did not light the lamp");

  a_fast_wins: assert property (@(posedge clock) disable iff (rst)
    lamp_nxt[0][STYLE_FAST] |=> (lamp_r[0] == $past(wave_fast)))
    else $error("fast blink did not take priority");

  a_lamp_idle: assert property (@(posedge clock) disable iff (rst)
    (trig_live == '0) |=> !lamp_r[0])
    else $error("lamp lit with no trigger");

  a_reverse_alert: assert property (@(posedge clock)
    disable iff (rst)
    moving_reverse |=> reverse_alert)
    else $error("reverse alert missed motion in reverse");

  a_speed_zero: assert property (@(posedge clock) disable iff (rst)
    range_lost |=> (speed_r == SPEED_ZERO && unknown_r))
    else $error("speed not zeroed on range loss");

  a_high_default: assert property (@(posedge clock)
    disable iff (rst)
    !corr_on |=> (speed_r == $past(speed_high_range)))
    else $error("speed did not assume high range");

  a_lock_holds: assert property (@(posedge clock) disable iff (rst)
    (range_lost ##1 (!range_lost && !lever_in_neutral)) |-> force_neutral)
    else $error("neutral lock released without lever cycle");

  a_impossible_err: assert property (@(posedge clock)
    disable iff (rst)
    (corr_on && range_pos == RNG_IMPOSSIBLE) |=>
      (err_range_high && err_range_low && force_neutral))
    else $error("impossible combination not reported");

  a_gear_out: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (gear_out ==
              $past(gear_set[{gear_engaged.dir, gear_engaged.range}])))
    else $error("gear output mismatch");

endmodule

// ---- rtl/annunciator_pkg.sv ----
// Constants and carrier types for the transmission annunciator block
package annunciator_pkg;

  // Warning condition indices
  localparam int NUM_COND          = 11;
  localparam int COND_NEAR_OVSPD   = 0;
  localparam int COND_OVERSPEED    = 1;
  localparam int COND_MAX_VSPEED   = 2;
  localparam int COND_LOW_PRESS    = 3;
  localparam int COND_CONV_TEMP    = 4;
  localparam int COND_REF_DIRCHG   = 5;
  localparam int COND_REF_ENGAGE   = 6;
  localparam int COND_REF_REENGAGE = 7;
  localparam int COND_REF_DOWNSH   = 8;
  localparam int COND_NEUTRAL_LOCK = 9;
  localparam int COND_DISP_ERROR   = 10;

  // Blink style codes
  localparam logic [1:0] STYLE_STEADY = 2'h0;
  localparam logic [1:0] STYLE_SLOW   = 2'h1;
  localparam logic [1:0] STYLE_NORMAL = 2'h2;
  localparam logic [1:0] STYLE_FAST   = 2'h3;

  // Default style table, two bits per condition
  localparam logic [21:0] STYLE_RESET = 22'h0002C0;

  // Default enable mask: the two extra triggers are off
  localparam logic [10:0] TRIG_RESET = 11'h1FF;

  // Clock and blink periods
  localparam int CLOCK_HZ        = 20000000;
  localparam int SLOW_PERIOD_MS  = 1000;
  localparam int NORM_PERIOD_MS  = 500;
  localparam int FAST_PERIOD_MS  = 250;
  localparam int SLOW_HALF_CYC   = SLOW_PERIOD_MS * (CLOCK_HZ / 2000);
  localparam int NORM_HALF_CYC   = NORM_PERIOD_MS * (CLOCK_HZ / 2000);
  localparam int FAST_HALF_CYC   = FAST_PERIOD_MS * (CLOCK_HZ / 2000);

  // Gear code: direction and range
  localparam logic [1:0] DIR_NEUTRAL = 2'h0;
  localparam logic [1:0] DIR_FORWARD = 2'h1;
  localparam logic [1:0] DIR_REVERSE = 2'h2;
  localparam int         RANGE_W     = 3;
  localparam int         GEAR_SLOTS  = 32;

  // Speed fields
  localparam int           SPEED_W      = 16;
  localparam logic [15:0]  SPEED_ZERO   = 16'h0000;

  typedef enum logic [1:0] {
    RNG_NEUTRAL,
    RNG_LOW,
    RNG_HIGH,
    RNG_IMPOSSIBLE
  } range_pos_e;

  typedef struct packed {
    logic [1:0]         dir;
    logic [RANGE_W-1:0] range;
  } gear_s;

  typedef struct packed {
    logic [SPEED_W-1:0] speed;
    logic               unknown;
  } speed_report_s;

endpackage

// ---- rtl/blink_gen.sv ----
// Free running square wave of programmable half period
module blink_gen
  import annunciator_pkg::*;
#(
  parameter int HALF_CYC = 1000
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Wave out
  output logic      wave
);

  localparam int CW = $clog2(HALF_CYC + 1);

  if (HALF_CYC < 2)
    $error("blink_gen: HALF_CYC must be at least 2");

  logic [CW-1:0] cnt_r;
  logic          wave_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_r  <= '0;
      wave_r <= 1'b0;
    end
    else if (cnt_r == CW'(HALF_CYC - 1))
    begin
      cnt_r  <= '0;
      wave_r <= ~wave_r;
    end
    else
      cnt_r <= cnt_r + CW'(1);
  end

  assign wave = wave_r;

  a_wave_period: assert property (@(posedge clock) disable iff (rst)
    (cnt_r != CW'(HALF_CYC - 1)) |=> (wave_r == $past(wave_r)))
    else $error("blink wave toggled early");

endmodule

// ---- verif/range_switch_model.sv ----
// Model of the two range position switches fitted by the vehicle builder
module range_switch_model
  import annunciator_pkg::*;
(
  // Requested mechanical position
  input  wire range_pos_e pos,
  // Switch contacts, closed reads high
  output logic            high_sw,
  output logic            low_sw
);
  timeunit 1ns;
  timeprecision 1ns;

  // One contact closes on high range, one on low range
  always_comb
  begin
    high_sw = (pos == RNG_HIGH) || (pos == RNG_IMPOSSIBLE);
    low_sw  = (pos == RNG_LOW) || (pos == RNG_IMPOSSIBLE);
  end
endmodule

// ---- verif/test_annunciator_outputs.sv ----
// Self-checking bench for the annunciator outputs block
module test_annunciator_outputs
  import annunciator_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clock;
  logic                  rst;
  logic [NUM_COND-1:0]   cond_active;
  logic [NUM_COND-1:0]   trig_enable;
  logic [2*NUM_COND-1:0] cond_style;
  logic [3*NUM_COND-1:0] lamp_subset;
  logic [GEAR_SLOTS-1:0] gear_set;
  logic                  range_sw_fitted;
  logic                  elec_range_enabled;
  gear_s                 gear_engaged;
  logic [1:0]            lever_dir;
  logic                  lever_in_neutral;
  logic                  moving_reverse;
  logic [SPEED_W-1:0]    spd_hi;
  logic [SPEED_W-1:0]    spd_lo;
  range_pos_e            range_pos;
  logic                  range_high_sw;
  logic                  range_low_sw;
  logic [0:0]            warn_lamp;
  logic                  can_warn_lamp;
  logic                  gear_out;
  logic                  reverse_alert;
  speed_report_s         speed_report;
  logic                  force_neutral;
  logic                  err_range_high;
  logic                  err_range_low;
  logic                  config_error;
  logic [2:0]            warn3;
  logic                  can3;
  int                    error_cnt;
  int                    total_checks;
  int                    cycles;

  annunciator_outputs #(.NUM_LAMPS(1), .SLOW_HALF(8), .NORM_HALF(4),
    .FAST_HALF(2)) annunciator_outputs_inst (
    .clock(clock), .rst(rst), .cond_active(cond_active),
    .cond_style(cond_style), .trig_enable(trig_enable),
    .lamp_subset(lamp_subset), .gear_set(gear_set),
    .range_sw_fitted(range_sw_fitted),
    .elec_range_enabled(elec_range_enabled),
    .gear_engaged(gear_engaged), .lever_dir(lever_dir),
    .lever_in_neutral(lever_in_neutral), .moving_reverse(moving_reverse),
    .speed_high_range(spd_hi), .speed_low_range(spd_lo),
    .range_high_sw(range_high_sw), .range_low_sw(range_low_sw),
    .warn_lamp(warn_lamp), .can_warn_lamp(can_warn_lamp),
    .gear_out(gear_out), .reverse_alert(reverse_alert),
    .speed_report(speed_report), .force_neutral(force_neutral),
    .err_range_high(err_range_high), .err_range_low(err_range_low),
    .config_error(config_error));

  annunciator_outputs #(.NUM_LAMPS(3), .SLOW_HALF(8), .NORM_HALF(4),
    .FAST_HALF(2)) annunciator_outputs_inst_3lamp (
    .clock(clock), .rst(rst), .cond_active(cond_active),
    .cond_style(cond_style), .trig_enable(trig_enable),
    .lamp_subset(lamp_subset), .gear_set(gear_set),
    .range_sw_fitted(range_sw_fitted),
    .elec_range_enabled(elec_range_enabled),
    .gear_engaged(gear_engaged), .lever_dir(lever_dir),
    .lever_in_neutral(lever_in_neutral), .moving_reverse(moving_reverse),
    .speed_high_range(spd_hi), .speed_low_range(spd_lo),
    .range_high_sw(range_high_sw), .range_low_sw(range_low_sw),
    .warn_lamp(warn3), .can_warn_lamp(can3),
    .gear_out(), .reverse_alert(),
    .speed_report(), .force_neutral(),
    .err_range_high(), .err_range_low(),
    .config_error());

  range_switch_model range_switch_model_inst (
    .pos(range_pos), .high_sw(range_high_sw), .low_sw(range_low_sw));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles >= 4000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Counts lamp edges over 32 cycles against the style's half period
  task automatic lamp_meas(input logic [1:0] sty);
    int   tg;
    int   ex;
    int   tol;
    logic prev;
    int   got;
    ex = sty == STYLE_FAST ? 16 : sty == STYLE_NORMAL ? 8 :
         sty == STYLE_SLOW ? 4 : 0;
    tol = (ex == 0) ? 0 : 1;
    tick(3);
    prev = warn_lamp[0];
    tg = 0;
    repeat (32)
    begin
      tick(1);
      chk(32'(can_warn_lamp), 32'(warn_lamp[0]));
      if (warn_lamp[0] !== prev)
        tg++;
      prev = warn_lamp[0];
    end
    if (ex == 0)
      chk(32'(warn_lamp[0]), 32'h1);
    got = (tg >= ex - tol && tg <= ex + tol) ? ex : tg;
    chk(32'(got), 32'(ex));
  endtask

  task automatic t_styles();
    cond_style = '0;
    cond_active = 11'h001;
    for (int s = 0; s < 4; s++)
    begin
      cond_style[1:0] = 2'(s);
      lamp_meas(2'(s));
    end
  endtask

  task automatic t_defaults();
    cond_style = STYLE_RESET;
    cond_active = 11'h00A;
    lamp_meas(STYLE_FAST);
    cond_active = 11'h011;
    lamp_meas(STYLE_NORMAL);
    cond_active = 11'h018;
    lamp_meas(STYLE_FAST);
    cond_active = 11'h004;
    lamp_meas(STYLE_STEADY);
  endtask

  task automatic t_triggers();
    for (int i = 5; i < 9; i++)
    begin
      cond_active = 11'(1 << i);
      lamp_meas(STYLE_STEADY);
    end
    cond_active = 11'h600;
    tick(3);
    chk(32'(warn_lamp[0]), 32'h0);
    trig_enable = 11'h7FF;
    cond_active = 11'h200;
    lamp_meas(STYLE_STEADY);
    cond_active = 11'h400;
    lamp_meas(STYLE_STEADY);
    cond_active = '0;
    tick(3);
    chk(32'({warn_lamp[0], can_warn_lamp}), 32'h0);
  endtask

  // Separate lamps each follow their own subset of conditions
  task automatic t_lamps();
    cond_style = '0;
    lamp_subset = {11'h008, 11'h010, 11'h007};
    cond_active = 11'h001;
    tick(3);
    chk(32'({warn3, can3}), 32'h3);
    cond_active = 11'h010;
    tick(3);
    chk(32'({warn3, can3}), 32'h5);
    cond_active = 11'h008;
    tick(3);
    chk(32'({warn3, can3}), 32'h9);
    cond_active = 11'h019;
    tick(3);
    chk(32'({warn3, can3}), 32'hF);
    cond_active = 11'h020;
    tick(3);
    chk(32'({warn3, can3}), 32'h1);
    cond_active = '0;
    cond_style = STYLE_RESET;
  endtask

  task automatic t_gear_rev();
    gear_set = GEAR_SLOTS'(1) << {DIR_FORWARD, 3'h3};
    for (int d = 0; d < 3; d++)
      for (int r = 0; r < 8; r++)
      begin
        gear_engaged = '{dir: 2'(d), range: 3'(r)};
        tick(2);
        chk(32'(gear_out), 32'(d == 1 && r == 3));
      end
    for (int i = 0; i < 8; i++)
    begin
      lever_dir = i[0] ? DIR_REVERSE : DIR_FORWARD;
      gear_engaged.dir = i[1] ? DIR_REVERSE : DIR_NEUTRAL;
      moving_reverse = i[2];
      tick(2);
      chk(32'(reverse_alert), 32'(i != 0));
    end
    lever_dir = DIR_FORWARD;
  endtask

  task automatic t_range();
    range_pos = RNG_LOW;
    tick(4);
    chk(32'(speed_report), 32'({spd_hi, 1'b0}));
    range_sw_fitted = 1'b1;
    tick(4);
    chk(32'(speed_report), 32'({spd_lo, 1'b0}));
    range_pos = RNG_HIGH;
    tick(4);
    chk(32'(speed_report), 32'({spd_hi, 1'b0}));
    chk(32'({force_neutral, err_range_high}), 32'h0);
    range_pos = RNG_NEUTRAL;
    tick(4);
    chk(32'(speed_report), 32'({SPEED_ZERO, 1'b1}));
    chk(32'(force_neutral), 32'h1);
    range_pos = RNG_HIGH;
    tick(4);
    chk(32'(force_neutral), 32'h1);
    lever_in_neutral = 1'b1;
    lever_dir = DIR_NEUTRAL;
    tick(3);
    chk(32'(force_neutral), 32'h1);
    lever_in_neutral = 1'b0;
    lever_dir = DIR_FORWARD;
    tick(3);
    chk(32'(force_neutral), 32'h0);
    range_pos = RNG_IMPOSSIBLE;
    tick(4);
    chk(32'(speed_report), 32'({SPEED_ZERO, 1'b1}));
    chk(32'({force_neutral, err_range_high, err_range_low}), 32'h7);
    elec_range_enabled = 1'b1;
    tick(4);
    chk(32'(config_error), 32'h1);
    chk(32'(speed_report), 32'({spd_hi, 1'b0}));
  endtask

  initial
  begin
    rst = 1'b1;
    cond_active = '0;
    trig_enable = TRIG_RESET;
    cond_style = STYLE_RESET;
    lamp_subset = '0;
    gear_set = '0;
    range_sw_fitted = 1'b0;
    elec_range_enabled = 1'b0;
    gear_engaged = '{dir: DIR_NEUTRAL, range: 3'h0};
    lever_dir = DIR_FORWARD;
    lever_in_neutral = 1'b0;
    moving_reverse = 1'b0;
    spd_hi = 16'h1234;
    spd_lo = 16'h0456;
    range_pos = RNG_HIGH;
    error_cnt = 0;
    total_checks = 0;
    cycles = 0;
    tick(4);
    rst = 1'b0;
    t_styles();
    t_defaults();
    t_triggers();
    t_lamps();
    t_gear_rev();
    t_range();
    results();
  end
endmodule
